/* verilog/pcd_pkg.sv */
package pcd_pkg;
	// Counter geometry
	localparam int NPOST = 6;
	localparam int NFAST = 4;
	localparam int NPH   = 8;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_PRE   = 8'h04;
	localparam logic [7:0] OFF_FB    = 8'h08;
	localparam logic [7:0] OFF_STAT  = 8'h0C;
	localparam logic [7:0] OFF_POST0 = 8'h10;

	// Control register fields
	localparam int POS_FAST    = 0;
	localparam int POS_RESTART = 1;

	// Post-divider register fields: high[8:0], low[17:9], tap[20:18], start[30:21]
	localparam int POS_HIGH  = 0;
	localparam int POS_LOW   = 9;
	localparam int POS_TAP   = 18;
	localparam int POS_START = 21;

	// Feedback register fields: m[9:0], tap[12:10], start[22:13]
	localparam int POS_M       = 0;
	localparam int POS_FTAP    = 10;
	localparam int POS_FSTART  = 13;

	// Status register fields
	localparam int POS_PRE_ERR  = 0;
	localparam int POS_FB_ERR   = 1;
	localparam int POS_POST_ERR = 2;

	// Reset values: every count 1, tap 0, start 1
	localparam logic [9:0]  RST_PRE  = 10'h001;
	localparam logic [31:0] RST_FB   = 32'h0000_2001;
	localparam logic [31:0] RST_POST = 32'h0020_0201;

	// Count limits per variant
	localparam logic [9:0] LIM_ENH      = 10'h200;
	localparam logic [9:0] LIM_ENH_ODD  = 10'h100;
	localparam logic [9:0] LIM_FAST_M   = 10'h020;
	localparam logic [9:0] LIM_FAST_N   = 10'h004;
	localparam logic [9:0] LIM_FAST_P   = 10'h020;
	localparam logic [9:0] LIM_FAST_ODD = 10'h010;

	// Range check of a plain count
	function automatic logic cnt_ok(input logic [9:0] v, input logic [9:0] lim);
		return (v != 10'h000) && (v <= lim);
	endfunction

	// Range check of a post divider from its high and low counts
	function automatic logic post_ok(input logic [8:0] h, input logic [8:0] l, input logic fast);
		logic [9:0] d;
		logic       half;
		logic [9:0] lim;
		d    = {1'b0, h} + {1'b0, l};
		half = (h == l) || (h == l + 9'h001);
		if (fast)
			lim = half ? LIM_FAST_P : LIM_FAST_ODD;
		else
			lim = half ? LIM_ENH : LIM_ENH_ODD;
		return (h != 9'h000) && (d <= lim);
	endfunction
endpackage

/* verilog/pcd_tick_if.sv */
`timescale 1ns/10ps
interface pcd_tick_if;
	logic [7:0] tick;     // One-cycle pulse per rising edge of each phase
	logic       ref_tick; // One-cycle pulse per reference rising edge
	logic       lvl0;     // Synchronised level of phase 0
	logic       ce;       // Clock enable

	modport prod (output tick, output ref_tick, output lvl0, input ce);
	modport cons (input tick, input ref_tick, input lvl0, input ce);
endinterface

/* verilog/pcd_phase_sync.sv */
`timescale 1ns/10ps
module pcd_phase_sync (
	input  wire logic       clk,       // Core clock
	input  wire logic       rst_n,     // Asynchronous reset, active low
	input  wire logic [7:0] phase_in,  // Oscillator phase pins
	input  wire logic       ref_in,    // Reference clock pin
	pcd_tick_if.prod        bus        // Tick outputs
);
	typedef struct packed {
		logic [8:0] s1;
		logic [8:0] s2;
		logic [8:0] s3;
	} pcd_sync_st_type;

	pcd_sync_st_type r;
	pcd_sync_st_type nxt;

	// Two-stage synchroniser; edges are taken only from the second stage
	always_comb begin
		nxt = r;
		if (bus.ce) begin
			nxt.s1 = {ref_in, phase_in};
			nxt.s2 = r.s1;
			nxt.s3 = r.s2;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			r <= '0;
		else
			r <= nxt;
	end

	// Rising-edge pulses, gated so a frozen block sees no ticks
	assign bus.tick     = r.s2[7:0] & ~r.s3[7:0] & {8{bus.ce}};
	assign bus.ref_tick = r.s2[8] & ~r.s3[8] & bus.ce;
	assign bus.lvl0     = r.s2[0];
endmodule

/* verilog/pcd_post_div.sv */
`timescale 1ns/10ps
module pcd_post_div (
	input  wire logic       clk,      // Core clock
	input  wire logic       rst_n,    // Asynchronous reset, active low
	pcd_tick_if.cons        bus,      // Phase ticks and clock enable
	input  wire logic       restart,  // Load settings and start together
	input  wire logic       cfg_ok,   // Settings are within range
	input  wire logic [2:0] tap,      // Oscillator phase used as counting clock
	input  wire logic [8:0] high,     // High-time count
	input  wire logic [8:0] low,      // Low-time count
	input  wire logic [9:0] start,    // Initial count, 1 means no delay
	output logic            div_out   // Divided clock, from a flip-flop
);
	typedef struct packed {
		logic [8:0] high;
		logic [8:0] low;
		logic [2:0] tap;
		logic [9:0] del;
		logic [9:0] cnt;
		logic       run;
		logic       out;
	} pcd_div_st_type;

	pcd_div_st_type r;
	pcd_div_st_type nxt;
	logic           tk;
	logic [9:0]     cnt_inc;
	logic [9:0]     period;

	assign tk      = bus.tick[r.tap]; // RQ8
	assign cnt_inc = r.cnt + 10'h001;
	assign period  = {1'b0, r.high} + {1'b0, r.low};

	// Settings are captured only at restart, so a divider never changes mid-period
	always_comb begin
		nxt = r;
		if (bus.ce) begin
			if (restart) begin
				nxt.high = high; // RQ15 RQ16
				nxt.low  = low;
				nxt.tap  = tap; // RQ9 RQ11 RQ12
				nxt.del  = (start == 10'h000) ? 10'h000 : start - 10'h001; // RQ10
				nxt.cnt  = 10'h000;
				nxt.run  = cfg_ok; // RQ17
				nxt.out  = 1'b0;
			end else if (r.run && tk) begin
				if (r.del != 10'h000) begin
					nxt.del = r.del - 10'h001; // RQ10
				end else begin
					// High for the first high ticks of a period, low for the rest
					nxt.out = (r.cnt < {1'b0, r.high}); // RQ2 RQ15
					nxt.cnt = (cnt_inc >= period) ? 10'h000 : cnt_inc;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			r <= '0;
		else
			r <= nxt;
	end

	assign div_out = r.out;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_idle_low;
		(!r.run && !(restart && bus.ce)) |=> !div_out;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("idle divider output high"); // RQ17

	property p_delay_hold;
		(r.del != 10'h000) |-> !div_out;
	endproperty
	a_delay_hold: assert property (p_delay_hold) else $error("output high during delay"); // RQ10

	property p_del_step;
		(r.run && r.del != 10'h000 && tk && bus.ce && !restart) |=> (r.del == $past(r.del) - 10'h001);
	endproperty
	a_del_step: assert property (p_del_step) else $error("delay not counted on tap"); // RQ10

	property p_high_first;
		(r.run && r.del == 10'h000 && r.cnt == 10'h000 && tk && !restart) |=> div_out;
	endproperty
	a_high_first: assert property (p_high_first) else $error("period did not start high"); // RQ15

	property p_low_tail;
		(r.run && r.del == 10'h000 && r.cnt >= {1'b0, r.high} && tk && !restart) |=> !div_out;
	endproperty
	a_low_tail: assert property (p_low_tail) else $error("low time not honoured"); // RQ15

	property p_tap_only;
		!(bus.ce && (tk || restart)) |=> $stable(div_out);
	endproperty
	a_tap_only: assert property (p_tap_only) else $error("output moved off its tap"); // RQ8

	c_delay_done: cover property (r.run && r.del == 10'h001 && tk ##1 r.del == 10'h000);
endmodule

/* verilog/pcd_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RQ1: The reference is divided by the pre-scale count n and the oscillator by m, for the loop.
// RQ2: Each output has its own post divider working from the oscillator, apart from the others.
// RQ3: In the enhanced variant n and m each accept 1 to 512.
// RQ4: In the fast variant m accepts 1 to 32 and n accepts 1 to 4.
// RQ5: The enhanced variant has six post dividers taking 1 to 512 at half duty cycle.
// RQ6: An enhanced post divider with another duty cycle is limited to 1 to 256.
// RQ7: The fast variant uses four post dividers, 1 to 32 at half duty and 1 to 16 otherwise.
// RQ8: Every post divider and the feedback counter pick any of the eight phases to count.
// RQ9: Moving to another phase tap shifts the output by one eighth of an oscillator period.
// RQ10: A counter start is held off for its initial count minus one oscillator periods.
// RQ11: Taps and start delays together shift every output in steps of 45 degrees or finer.
// RQ12: Output phase shift comes only from the chosen tap and the counter start time.
// RQ13: No analog delay elements exist; all delay comes from counters.
// RQ14: A dedicated output carries the undivided oscillator clock for serialiser logic.
// RQ15: Duty cycle is set by high and low counts whose sum is the divide value.
// RQ16: Duty cycle resolution is one half over the divide value; the code steps the high count by one tick, so its resolution is one over it.
// RQ17: All settings are static and take effect when all counters restart together.
module pcd_top (
	input  wire logic        hclk,           // Bus and counter clock
	input  wire logic        hresetn,        // Asynchronous reset, active low
	input  wire logic        hsel,           // Slave select
	input  wire logic [31:0] haddr,          // Byte address
	input  wire logic [1:0]  htrans,         // Transfer type
	input  wire logic        hwrite,         // Write when high
	input  wire logic [2:0]  hsize,          // Word transfers only
	input  wire logic [31:0] hwdata,         // Write data
	input  wire logic        hready,         // Bus ready
	input  wire logic        ce,             // Freezes all counting while low
	input  wire logic [7:0]  vco_phase,      // Eight oscillator phases
	input  wire logic        ref_clk,        // Reference clock
	output logic      [31:0] hrdata,         // Read data
	output logic             hreadyout,      // Low during reset, high from the first clock edge after
	output logic             hresp,          // Always OKAY
	output logic      [5:0]  clk_out,        // Post divider outputs
	output logic             fb_clk_out,     // Feedback counter output
	output logic             ref_div_out,    // Pre-scaled reference
	output logic             serdes_clk_out  // Undivided oscillator clock
);
	typedef struct packed {
		logic [7:0]                        addr;
		logic                              wr_pend;
		logic                              fast;
		logic                              restart;
		logic [9:0]                        pre;
		logic [31:0]                       fb;
		logic [pcd_pkg::NPOST-1:0][31:0]   post;
		logic [31:0]                       rdata;
		logic [9:0]                        n_lat;
		logic [9:0]                        n_cnt;
		logic                              n_run;
		logic                              n_out;
		logic                              ser;
	} pcd_top_st_type;

	pcd_top_st_type              r;
	pcd_top_st_type              nxt;
	pcd_tick_if                  tb ();
	logic                        take;
	logic                        mapped;
	logic                        pre_ok;
	logic                        fb_ok;
	logic [pcd_pkg::NPOST-1:0]   post_ok_v;
	logic [pcd_pkg::NPOST-1:0]   post_q;
	logic                        fb_q;
	logic [9:0]                  m_val;
	logic [9:0]                  n_inc;

	assign tb.ce = ce;

	// Post register window test and index
	function automatic logic is_post(input logic [7:0] a);
		return (a >= pcd_pkg::OFF_POST0) && (a < pcd_pkg::OFF_POST0 + 8'h18);
	endfunction

	function automatic logic [2:0] post_ix(input logic [7:0] a);
		logic [7:0] d;
		d = a - pcd_pkg::OFF_POST0;
		return d[4:2];
	endfunction

	// Range checks against the variant in force
	assign m_val  = r.fb[pcd_pkg::POS_M +: 10];
	assign pre_ok = pcd_pkg::cnt_ok(r.pre, r.fast ? pcd_pkg::LIM_FAST_N : pcd_pkg::LIM_ENH); // RQ3 RQ4
	assign fb_ok  = pcd_pkg::cnt_ok(m_val, r.fast ? pcd_pkg::LIM_FAST_M : pcd_pkg::LIM_ENH)
		&& pcd_pkg::cnt_ok(r.fb[pcd_pkg::POS_FSTART +: 10], pcd_pkg::LIM_ENH); // RQ3 RQ4

	for (genvar i = 0; i < pcd_pkg::NPOST; i++) begin : g_post
		// Dividers beyond the fast set stay idle in the fast variant
		assign post_ok_v[i] = pcd_pkg::post_ok(r.post[i][pcd_pkg::POS_LOW - 1:pcd_pkg::POS_HIGH],
			r.post[i][pcd_pkg::POS_TAP - 1:pcd_pkg::POS_LOW], r.fast) // RQ5 RQ6 RQ7
			&& pcd_pkg::cnt_ok(r.post[i][pcd_pkg::POS_START +: 10], pcd_pkg::LIM_ENH)
			&& !(r.fast && i >= pcd_pkg::NFAST); // RQ7

		pcd_post_div u_post (
			.clk     (hclk),
			.rst_n   (hresetn),
			.bus     (tb.cons),
			.restart (r.restart),
			.cfg_ok  (post_ok_v[i]),
			.tap     (r.post[i][pcd_pkg::POS_TAP +: 3]),
			.high    (r.post[i][pcd_pkg::POS_HIGH +: 9]),
			.low     (r.post[i][pcd_pkg::POS_LOW +: 9]),
			.start   (r.post[i][pcd_pkg::POS_START +: 10]),
			.div_out (post_q[i])
		); // RQ2
	end

	// Feedback counter: high (m+1)/2 and low m/2 ticks, so 50% duty for even m and one tick longer high for odd m
	pcd_post_div u_fb (
		.clk     (hclk),
		.rst_n   (hresetn),
		.bus     (tb.cons),
		.restart (r.restart),
		.cfg_ok  (fb_ok),
		.tap     (r.fb[pcd_pkg::POS_FTAP +: 3]),
		.high    (9'((m_val + 10'h001) >> 1)),
		.low     (9'(m_val >> 1)),
		.start   (r.fb[pcd_pkg::POS_FSTART +: 10]),
		.div_out (fb_q)
	); // RQ1 RQ8

	pcd_phase_sync u_sync (
		.clk      (hclk),
		.rst_n    (hresetn),
		.phase_in (vco_phase),
		.ref_in   (ref_clk),
		.bus      (tb.prod)
	);

	assign take   = hsel && hready && htrans[1];
	assign mapped = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
	assign n_inc  = r.n_cnt + 10'h001;

	// Register file, pre-scale counter and serialiser clock
	always_comb begin
		nxt         = r;
		nxt.restart = 1'b0;
		nxt.wr_pend = take && hwrite && mapped;
		if (take) begin
			nxt.addr = haddr[7:0];
		end
		// Read data is prepared in the address phase and stands in the data phase
		if (take && !hwrite) begin
			nxt.rdata = 32'h0000_0000;
			if (mapped) begin
				case (haddr[7:0])
					pcd_pkg::OFF_CTRL: begin
						nxt.rdata[pcd_pkg::POS_FAST] = r.fast;
					end
					pcd_pkg::OFF_PRE: begin
						nxt.rdata[9:0] = r.pre;
					end
					pcd_pkg::OFF_FB: begin
						nxt.rdata = r.fb;
					end
					pcd_pkg::OFF_STAT: begin
						nxt.rdata[pcd_pkg::POS_PRE_ERR] = !pre_ok;
						nxt.rdata[pcd_pkg::POS_FB_ERR] = !fb_ok;
						nxt.rdata[pcd_pkg::POS_POST_ERR +: pcd_pkg::NPOST] = ~post_ok_v;
					end
					default: begin
						if (is_post(haddr[7:0]))
							nxt.rdata = r.post[post_ix(haddr[7:0])];
					end
				endcase
			end
		end
		if (r.wr_pend) begin
			case (r.addr)
				pcd_pkg::OFF_CTRL: begin
					nxt.fast    = hwdata[pcd_pkg::POS_FAST];
					nxt.restart = hwdata[pcd_pkg::POS_RESTART]; // RQ17
				end
				pcd_pkg::OFF_PRE: begin
					nxt.pre = hwdata[9:0];
				end
				pcd_pkg::OFF_FB: begin
					nxt.fb = hwdata;
				end
				default: begin
					if (is_post(r.addr))
						nxt.post[post_ix(r.addr)] = hwdata;
				end
			endcase
		end
		// Counting state is frozen while ce is low; the bus keeps working
		if (ce) begin
			nxt.ser = tb.lvl0; // RQ14
			if (r.restart) begin
				nxt.n_lat = r.pre; // RQ17
				nxt.n_cnt = 10'h000;
				nxt.n_run = pre_ok;
				nxt.n_out = 1'b0;
			end else if (r.n_run && tb.ref_tick) begin
				nxt.n_out = (r.n_cnt < ((r.n_lat + 10'h001) >> 1)); // RQ1
				nxt.n_cnt = (n_inc >= r.n_lat) ? 10'h000 : n_inc;
			end
		end
	end

	// Reset leaves a restart pending so all counters start together
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r         <= '0;
			r.pre     <= pcd_pkg::RST_PRE;
			r.fb      <= pcd_pkg::RST_FB;
			r.post    <= {pcd_pkg::NPOST{pcd_pkg::RST_POST}};
			r.restart <= 1'b1;
			hreadyout <= 1'b0;
		end else begin
			r         <= nxt;
			hreadyout <= 1'b1;
		end
	end

	// Phase delay comes from counter start and tap only, never from delay cells
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_out    <= 6'h00;
			fb_clk_out <= 1'b0;
		end else begin
			clk_out    <= post_q; // RQ11 RQ12 RQ13
			fb_clk_out <= fb_q;
		end
	end

	assign hrdata         = r.rdata;
	assign hresp          = 1'b0;
	assign ref_div_out    = r.n_out;
	assign serdes_clk_out = r.ser;

	default clocking cbt @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_restart;
		(r.wr_pend && r.addr == pcd_pkg::OFF_CTRL && hwdata[pcd_pkg::POS_RESTART])
			|=> r.restart ##1 !r.restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart write not pulsed"); // RQ17

	property p_fast_n;
		(r.fast && r.pre > pcd_pkg::LIM_FAST_N) |-> !pre_ok;
	endproperty
	a_fast_n: assert property (p_fast_n) else $error("fast n above 4 accepted"); // RQ4

	property p_enh_m;
		(!r.fast && m_val != 10'h000) |-> fb_ok == (m_val <= pcd_pkg::LIM_ENH
			&& r.fb[pcd_pkg::POS_FSTART +: 10] != 10'h000
			&& r.fb[pcd_pkg::POS_FSTART +: 10] <= pcd_pkg::LIM_ENH);
	endproperty
	a_enh_m: assert property (p_enh_m) else $error("enhanced m range wrong"); // RQ3

	property p_fast_extra;
		r.fast |-> !post_ok_v[4] && !post_ok_v[5];
	endproperty
	a_fast_extra: assert property (p_fast_extra) else $error("fast variant used extra divider"); // RQ7

	property p_odd_limit;
		(!r.fast && r.post[0][8:0] > r.post[0][17:9] + 9'h001
			&& ({1'b0, r.post[0][8:0]} + {1'b0, r.post[0][17:9]}) > pcd_pkg::LIM_ENH_ODD)
			|-> !post_ok_v[0];
	endproperty
	a_odd_limit: assert property (p_odd_limit) else $error("non-half divide above 256"); // RQ6

	property p_rd_pre;
		(take && !hwrite && haddr == 32'h0000_0004) |=> hrdata == {22'h00_0000, $past(r.pre)};
	endproperty
	a_rd_pre: assert property (p_rd_pre) else $error("pre-scale read back wrong"); // RQ3

	// A pre-scale write lands one edge after its data phase
	property p_wr_pre;
		(r.wr_pend && r.addr == pcd_pkg::OFF_PRE) |=> r.pre == $past(hwdata[9:0]);
	endproperty
	a_wr_pre: assert property (p_wr_pre) else $error("pre-scale write lost"); // RQ3

	// The divided reference moves only on a reference tick or a restart
	property p_ref_tick;
		!(ce && (tb.ref_tick || r.restart)) |=> $stable(ref_div_out);
	endproperty
	a_ref_tick: assert property (p_ref_tick) else $error("reference divider off its tick"); // RQ1

	// A restart with ce high brings the divided reference back low
	property p_n_restart;
		(ce && r.restart) |=> !ref_div_out;
	endproperty
	a_n_restart: assert property (p_n_restart) else $error("reference not reloaded"); // RQ17

	// Serialiser clock is the synchronised phase 0 level, one flop later
	property p_serdes;
		ce |=> serdes_clk_out == $past(tb.lvl0);
	endproperty
	a_serdes: assert property (p_serdes) else $error("serdes clock not undivided"); // RQ14

	// With ce low nothing moves; clk_out trails the dividers by one flop
	property p_freeze;
		!ce |=> ($stable(ref_div_out) && $stable(serdes_clk_out)) ##1 ($stable(clk_out)
			&& $stable(fb_clk_out));
	endproperty
	a_freeze: assert property (p_freeze) else $error("output moved while frozen"); // RQ17

	c_fast_mode: cover property (r.wr_pend && r.addr == pcd_pkg::OFF_CTRL ##1 r.fast);
	c_ref_div: cover property (r.n_run && r.n_lat == 10'h003 && r.n_out ##[1:40] !r.n_out);
	c_freeze: cover property (!ce ##1 !ce);
endmodule

/* testbench/pcd_osc_model.sv */
`timescale 1ns/10ps
module pcd_osc_model (
	input  wire logic       run,       // Starts the oscillator from phase 0
	output logic      [7:0] vco_phase, // Eight phases, one step apart
	output logic            ref_clk    // Reference clock
);
	localparam int STEP = 8; // One phase step in ns, one bus clock
	int s;

	// Phase k rises k steps after phase 0, so taps sit an eighth apart
	// Stopped oscillator holds every line low, so no stale edge is seen
	initial begin
		s = 0;
		vco_phase = 8'h00;
		ref_clk = 1'b0;
		#3;
		forever begin
			if (run !== 1'b1)
				s = 0;
			for (int k = 0; k < 8; k++)
				vco_phase[k] = (run === 1'b1) && (s >= k) && (((s - k) % 8) < 4);
			ref_clk = (run === 1'b1) && ((s % 16) < 8);
			if (run === 1'b1)
				s++;
			#STEP;
		end
	end
endmodule

/* testbench/test_pll_counter_phase_divider.sv */
`timescale 1ns/10ps
module test_pll_counter_phase_divider;
	localparam int VP = 8;  // Oscillator period in bus clocks
	localparam int RP = 16; // Reference period in bus clocks
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        ce;
	logic        run;
	logic [7:0]  vco_phase;
	logic        ref_clk;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [5:0]  clk_out;
	logic        fb_clk_out;
	logic        ref_div_out;
	logic        serdes_clk_out;
	logic [8:0]  obs;
	logic [8:0]  obs_q;
	logic [31:0] rd;
	int          cyc;
	int          fails;
	int          n_compared;
	int          first_r[9];
	int          prev_r[9];
	int          last_r[9];
	int          last_f[9];
	int          n_r[9];

	pcd_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .ce, .vco_phase, .ref_clk, .hrdata, .hreadyout, .hresp,
		.clk_out, .fb_clk_out, .ref_div_out, .serdes_clk_out);
	pcd_osc_model osc_u (.run, .vco_phase, .ref_clk);

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) cyc <= cyc + 1;

	// Edge log taken on the falling edge, clear of the bus drivers
	assign obs = {serdes_clk_out, ref_div_out, fb_clk_out, clk_out};
	always @(negedge hclk) begin
		for (int i = 0; i < 9; i++) begin
			if (obs[i] === 1'b1 && obs_q[i] !== 1'b1) begin
				if (n_r[i] == 0)
					first_r[i] = cyc;
				prev_r[i] = last_r[i];
				last_r[i] = cyc;
				n_r[i]++;
			end
			if (obs[i] === 1'b0 && obs_q[i] === 1'b1)
				last_f[i] = cyc;
		end
		obs_q = obs;
	end

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single word transfer; waits on ready in both phases
	// A stuck slave is left to the watchdog, which counts it as a failure
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000);
		chk(what, exp, rd);
	endtask

	function automatic logic [7:0] pa(input int i);
		return pcd_pkg::OFF_POST0 + 8'(4 * i);
	endfunction

	function automatic logic [31:0] pv(input logic [8:0] h, input logic [8:0] l,
		input logic [2:0] t, input logic [9:0] s);
		return {1'b0, s, t, l, h};
	endfunction

	function automatic logic [31:0] fv(input logic [9:0] m);
		return {9'h000, 10'h001, 3'h0, m};
	endfunction

	// Stop the oscillator, restart all counters, then start it from phase 0
	task automatic go(input logic fast, input int n);
		run <= 1'b0;
		wr(pcd_pkg::OFF_CTRL, {30'h00000000, 1'b1, fast});
		repeat (4) @(posedge hclk);
		for (int i = 0; i < 9; i++) begin
			n_r[i] = 0;
			first_r[i] = 0;
			prev_r[i] = 0;
			last_r[i] = 0;
			last_f[i] = 0;
		end
		run <= 1'b1;
		repeat (n) @(posedge hclk);
	endtask

	// Period and high time from the latest rising and falling edges
	task automatic per(input string what, input int i, input int p, input int h);
		int hi;
		hi = (last_f[i] > last_r[i]) ? last_f[i] - last_r[i] : last_f[i] - prev_r[i];
		chk(what, 32'(p), 32'(last_r[i] - prev_r[i]));
		chk(what, 32'(h), 32'(hi));
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		$display("watchdog expired");
		stop_test();
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		ce = 1'b1;
		run = 1'b0;
		cyc = 0;
		fails = 0;
		n_compared = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, read-only status and an unmapped place
		rdc("ctrl", pcd_pkg::OFF_CTRL, 32'h00000000);
		rdc("pre", pcd_pkg::OFF_PRE, 32'h00000001);
		rdc("fb", pcd_pkg::OFF_FB, pcd_pkg::RST_FB);
		for (int i = 0; i < 6; i++)
			rdc("post", pa(i), pcd_pkg::RST_POST);
		wr(pcd_pkg::OFF_STAT, 32'hFFFFFFFF);
		rdc("stat", pcd_pkg::OFF_STAT, 32'h00000000);
		wr(8'h40, 32'hFFFFFFFF);
		rdc("unmapped", 8'h40, 32'h00000000);
		chk("hresp", 32'h00000000, {31'h0, hresp});
		$display("test registers done");
		// Taps, start delay, feedback, pre-scale and serdes clock
		wr(pcd_pkg::OFF_PRE, 32'h00000002);
		wr(pcd_pkg::OFF_FB, fv(10'h003));
		wr(pa(0), pv(9'h002, 9'h002, 3'h0, 10'h001));
		wr(pa(1), pv(9'h002, 9'h002, 3'h3, 10'h001));
		wr(pa(2), pv(9'h002, 9'h002, 3'h0, 10'h003));
		go(1'b0, 300);
		chk("tap offset", 32'h00000003, 32'(first_r[1] - first_r[0]));
		chk("start delay", 32'(2 * VP), 32'(first_r[2] - first_r[0]));
		per("post0", 0, 4 * VP, 2 * VP);
		per("feedback", 6, 3 * VP, 2 * VP);
		per("ref div", 7, 2 * RP, RP);
		per("serdes", 8, VP, VP / 2);
		$display("test phase done");
		// New counts wait for the next restart
		wr(pa(0), pv(9'h003, 9'h001, 3'h0, 10'h001));
		repeat (100) @(posedge hclk);
		per("post0 held", 0, 4 * VP, 2 * VP);
		go(1'b0, 300);
		per("post0 reloaded", 0, 4 * VP, 3 * VP);
		$display("test reload done");
		// Enhanced limits, refused counters stay idle
		wr(pcd_pkg::OFF_PRE, 32'h00000000);
		wr(pcd_pkg::OFF_FB, fv(10'h201));
		wr(pa(0), pv(9'h0C8, 9'h064, 3'h0, 10'h001));
		wr(pa(2), pv(9'h0C8, 9'h038, 3'h0, 10'h001));
		wr(pa(3), pv(9'h0C8, 9'h064, 3'h0, 10'h001));
		wr(pa(4), pv(9'h100, 9'h100, 3'h0, 10'h001));
		wr(pa(5), pv(9'h000, 9'h002, 3'h0, 10'h001));
		go(1'b0, 100);
		rdc("stat enhanced", pcd_pkg::OFF_STAT, 32'h000000A7);
		chk("refused idle", 32'h00000000, 32'(n_r[0] + n_r[3] + n_r[5]));
		chk("refused low", 32'h00000000, {29'h0, clk_out[5], clk_out[3], clk_out[0]});
		wr(pcd_pkg::OFF_PRE, 32'h00000200);
		wr(pcd_pkg::OFF_FB, fv(10'h200));
		go(1'b0, 20);
		rdc("stat top counts", pcd_pkg::OFF_STAT, 32'h000000A4);
		$display("test enhanced limits done");
		// Fast variant limits and its four dividers
		wr(pcd_pkg::OFF_PRE, 32'h00000005);
		wr(pcd_pkg::OFF_FB, fv(10'h021));
		wr(pa(0), pv(9'h010, 9'h010, 3'h0, 10'h001));
		wr(pa(1), pv(9'h009, 9'h008, 3'h0, 10'h001));
		wr(pa(2), pv(9'h00A, 9'h007, 3'h0, 10'h001));
		go(1'b1, 20);
		rdc("ctrl fast", pcd_pkg::OFF_CTRL, 32'h00000001);
		xfer(1'b0, pcd_pkg::OFF_STAT, 32'h00000000);
		chk("stat fast", 32'h000000F3, rd);
		wr(pcd_pkg::OFF_PRE, 32'h00000004);
		wr(pcd_pkg::OFF_FB, fv(10'h020));
		go(1'b1, 700);
		xfer(1'b0, pcd_pkg::OFF_STAT, 32'h00000000);
		chk("stat fast top", 32'h000000F0, rd);
		per("fast post0", 0, 32 * VP, 16 * VP);
		chk("fast idle", 32'h00000000, 32'(n_r[2] + n_r[4] + n_r[5]));
		chk("fast low", 32'h00000000, {28'h0, clk_out[5:2]});
		$display("test fast variant done");
		// Clock enable low freezes every clock output; the bus keeps answering
		ce <= 1'b0;
		repeat (3) @(posedge hclk);
		rd = {23'h000000, obs};
		repeat (40) @(posedge hclk);
		chk("ce freeze", rd, {23'h000000, obs});
		rdc("ctrl while frozen", pcd_pkg::OFF_CTRL, 32'h00000001);
		ce <= 1'b1;
		$display("test clock enable done");
		stop_test();
	end
endmodule
